/* File: core/osr_top.sv */
// Purpose: output shutdown request unit with apb registers and interrupt
// Assumes: request pins are asynchronous and active low
// Notes: pslverr answers unmapped offsets; reads answer in the first access cycle
module osr_top import osr_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [OSR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // shutdown request pins, active low
    input wire logic [3:0] shutdown_request_pin_n,
    // motor timer drive and the seven motor pins
    input wire osr_mtr_drive_t mtr_drive,
    output logic [6:0] motor_pin_out,
    output logic [6:0] motor_pin_oe_n,
    // interrupt, level
    output logic irq
);
    // reset release through two flops
    logic [1:0] rst_sync_reg;
    logic rst_sys_n;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_sys_n = rst_sync_reg[1];

    // register state
    logic [7:0] mode_reg; // two mode bits per request
    logic irqen_reg; // interrupt enable of the flag request
    logic [3:0] flag_reg; // latched request flags
    logic [3:0] seen_reg; // flag was read as one
    logic [3:0] pinsel_reg; // pin routed to the request input
    logic [3:0] evt_stat_reg; // sticky request events
    logic [3:0] evt_mask_reg; // event interrupt mask
    logic [3:0] flag_next;
    logic [3:0] seen_next;
    logic [3:0] evt_stat_next;

    // apb answer, interrupt and motor pin output flops
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic [6:0] pin_out_reg;
    logic [6:0] pin_oe_n_reg;

    // bus decode
    logic setup;
    logic done;
    logic wr_done;
    logic hit_ics;
    logic hit_pinctl;
    logic hit_stat;
    logic hit_mask;
    logic hit_any;
    logic [15:0] ics_value;
    logic [31:0] rd_mux;
    logic rd_ics_done;
    logic rd_stat_done;

    assign setup = psel && !penable;
    assign done = psel && penable && pready_reg;
    assign wr_done = done && pwrite;
    assign hit_ics = (paddr == OSR_ICS_OFF);
    assign hit_pinctl = (paddr == OSR_PINCTL_OFF);
    assign hit_stat = (paddr == OSR_EVT_STAT_OFF);
    assign hit_mask = (paddr == OSR_EVT_MASK_OFF);
    assign hit_any = hit_ics || hit_pinctl || hit_stat || hit_mask;
    assign rd_ics_done = done && !pwrite && hit_ics;
    assign rd_stat_done = done && !pwrite && hit_stat;

    // reserved ics bits 11:9 read zero
    assign ics_value = {flag_reg, 3'h0, irqen_reg, mode_reg};
    // reserved pin control bits read zero
    assign rd_mux = hit_ics ? {16'h0, ics_value} :
                    hit_pinctl ? {24'h0, pinsel_reg, 4'h0} :
                    hit_stat ? {28'h0, evt_stat_reg} :
                    hit_mask ? {28'h0, evt_mask_reg} : 32'h0;

    // apb answer: data and ready prepared in the setup cycle, so no wait state
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            if (setup) begin
                prdata_reg <= pwrite ? 32'h0 : rd_mux;
                pslverr_reg <= !hit_any;
            end
        end
    end

    // request pin synchroniser; first stage feeds only the second
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            pin_meta_reg <= 4'hf;
            pin_sync_reg <= 4'hf;
        end else begin
            pin_meta_reg <= shutdown_request_pin_n;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // sampling strobes shared by all detectors
    logic [2:0] stb;
    logic [3:0] acc;

    osr_sample_div u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_sys_n),
        .stb(stb)
    );

    // per-request detection, flag and event logic
    genvar gi;
    generate
        for (gi = 0; gi < OSR_NUM_REQ; gi++) begin : g_req
            osr_req_cfg_t cfg;
            logic lvl;
            logic clr;

            assign cfg.mode = mode_reg[2*gi+1 -: 2];
            assign cfg.pin_sel = pinsel_reg[gi];
            // an unrouted pin looks idle high, so it never requests
            assign lvl = cfg.pin_sel ? pin_sync_reg[gi] : 1'b1;
            // only a zero write clears, and only after the flag read as one
            assign clr = wr_done && hit_ics && pstrb[1] && !pwdata[OSR_ICS_FLAG_LSB+gi] && seen_reg[gi];
            // a new request wins over a clear in the same cycle
            assign flag_next[gi] = acc[gi] || (flag_reg[gi] && !clr);
            assign seen_next[gi] = flag_next[gi] && !clr &&
                                   (seen_reg[gi] || (rd_ics_done && prdata_reg[OSR_ICS_FLAG_LSB+gi]));
            assign evt_stat_next[gi] = (acc[gi] && !flag_reg[gi]) ||
                                       (evt_stat_reg[gi] && !(rd_stat_done && prdata_reg[gi]));

            osr_req_detect u_det (
                .clk_sys(clk_sys),
                .rst_n(rst_sys_n),
                .req_lvl(lvl),
                .mode(cfg.mode),
                .stb(stb),
                .accept(acc[gi])
            );
        end
    endgenerate

    // software registers; flags only through flag_next
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            mode_reg <= OSR_MODE_RST;
            irqen_reg <= 1'b0;
            pinsel_reg <= OSR_PINSEL_RST;
            evt_mask_reg <= OSR_EVT_MASK_RST;
        end else if (wr_done) begin
            if (hit_ics && pstrb[0]) begin
                mode_reg <= pwdata[OSR_ICS_MODE_LSB +: 8];
            end
            if (hit_ics && pstrb[1]) begin
                irqen_reg <= pwdata[OSR_ICS_IRQEN_BIT];
            end
            if (hit_pinctl && pstrb[0]) begin
                pinsel_reg <= pwdata[OSR_PINCTL_SEL_LSB +: 4];
            end
            if (hit_mask && pstrb[0]) begin
                evt_mask_reg <= pwdata[3:0];
            end
        end
    end

    // flags, read markers and sticky events
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            flag_reg <= OSR_FLAG_RST;
            seen_reg <= 4'h0;
            evt_stat_reg <= 4'h0;
        end else begin
            flag_reg <= flag_next;
            seen_reg <= seen_next;
            evt_stat_reg <= evt_stat_next;
        end
    end

    // motor pin drive; force holds while any flag is set
    logic force_off;
    logic [6:0] oe_n_next;

    assign force_off = |flag_reg;
    // only pins in motor use are forced; port and pulse-unit pins pass
    assign oe_n_next = ~(mtr_drive.en & ~({OSR_NUM_MTR{force_off}} & mtr_drive.is_mtr));

    // output flops and interrupt level
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            pin_out_reg <= 7'h00;
            pin_oe_n_reg <= 7'h7f;
            irq_reg <= 1'b0;
        end else begin
            pin_out_reg <= mtr_drive.data;
            pin_oe_n_reg <= oe_n_next;
            irq_reg <= (irqen_reg && force_off) || |(evt_stat_reg & evt_mask_reg);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign motor_pin_out = pin_out_reg;
    assign motor_pin_oe_n = pin_oe_n_reg;
    assign irq = irq_reg;

    // checks on the local domain
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sys_n);

    a_sync_two_stage: assert property (
        $fell(pin_sync_reg[0]) |-> !$past(shutdown_request_pin_n[0], 2)) else $error("pin not two-stage synced");
    a_flag_no_set: assert property (
        wr_done && hit_ics && acc == 4'h0 && flag_reg == 4'h0 |=> flag_reg == 4'h0) else $error("write set a flag");
    a_flag_needs_read: assert property (
        flag_reg[0] && !seen_reg[0] |=> flag_reg[0]) else $error("flag cleared without read");
    a_accept_sets: assert property (
        |acc |=> (flag_reg & $past(acc)) == $past(acc)) else $error("accept did not set flag");
    a_force_hiz: assert property (
        force_off |=> (pin_oe_n_reg | ~$past(mtr_drive.is_mtr)) == 7'h7f) else $error("motor pin not forced");
    a_other_pass: assert property (
        rst_sys_n |=> (pin_oe_n_reg | $past(mtr_drive.is_mtr)) == (~$past(mtr_drive.en) | $past(mtr_drive.is_mtr)))
        else $error("non-motor pin disturbed");
    a_release_drive: assert property (
        !force_off && rst_sys_n |=> pin_oe_n_reg == ~$past(mtr_drive.en)) else $error("outputs not released");
    a_irq_level: assert property (
        irqen_reg && force_off |=> irq_reg) else $error("interrupt not raised");
    a_pinctl_hold: assert property (
        !(wr_done && hit_pinctl) |=> $stable(pinsel_reg)) else $error("pin select changed unwritten");
    a_resv_zero: assert property (
        setup && !pwrite && hit_pinctl |=> prdata_reg[3:0] == 4'h0) else $error("reserved bits not zero");
    a_apb_ready: assert property (
        setup |=> pready_reg ##1 !pready_reg || setup) else $error("apb ready timing wrong");

    c_flag_set: cover property (acc[0] && !flag_reg[0]);
    c_flag_clear: cover property (flag_reg[1] ##1 !flag_reg[1]);
    c_irq_up: cover property ($rose(irq_reg));
    c_bad_addr: cover property (done && pslverr_reg);
endmodule

/* File: include/osr_pkg.sv */
// Purpose: shared constants and carrier types of the output shutdown request unit
// Assumes: 32-bit apb data, one aligned word per register
// Notes: mode codes and field positions are fixed by the register layout
package osr_pkg;
    // sizes of the block
    localparam int OSR_NUM_REQ = 4;
    localparam int OSR_NUM_MTR = 7;
    localparam int OSR_ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OSR_ICS_OFF = 8'h00;
    localparam logic [7:0] OSR_PINCTL_OFF = 8'h04;
    localparam logic [7:0] OSR_EVT_STAT_OFF = 8'h08;
    localparam logic [7:0] OSR_EVT_MASK_OFF = 8'h0c;

    // field positions in input_control_status
    localparam int OSR_ICS_MODE_LSB = 0;
    localparam int OSR_ICS_IRQEN_BIT = 8;
    localparam int OSR_ICS_FLAG_LSB = 12;
    // field position in shutdown_pin_control
    localparam int OSR_PINCTL_SEL_LSB = 4;

    // values after reset
    localparam logic [7:0] OSR_MODE_RST = 8'h00;
    localparam logic [3:0] OSR_FLAG_RST = 4'h0;
    localparam logic [3:0] OSR_PINSEL_RST = 4'h0;
    localparam logic [3:0] OSR_EVT_MASK_RST = 4'h0;

    // input mode codes
    localparam logic [1:0] OSR_MODE_EDGE = 2'h0;
    localparam logic [1:0] OSR_MODE_DIV8 = 2'h1;
    localparam logic [1:0] OSR_MODE_DIV16 = 2'h2;
    localparam logic [1:0] OSR_MODE_DIV128 = 2'h3;

    // sampling divide ratios and the low-sample run length
    localparam int OSR_DIV8 = 8;
    localparam int OSR_DIV16 = 16;
    localparam int OSR_DIV128 = 128;
    localparam int OSR_LOW_SAMPLES = 16;

    // per-request configuration as seen by one detector
    typedef struct packed {
        logic [1:0] mode;
        logic pin_sel;
    } osr_req_cfg_t;

    // drive coming from the motor timer for its seven pins
    typedef struct packed {
        logic [6:0] data;
        logic [6:0] en;
        logic [6:0] is_mtr;
    } osr_mtr_drive_t;
endpackage

/* File: core/osr_sample_div.sv */
// Purpose: free-running divider giving the three sampling strobes
// Assumes: strobes are one clk_sys cycle wide
// Notes: all three strobes share one counter so their phases are fixed
module osr_sample_div import osr_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // strobes: bit0 div8, bit1 div16, bit2 div128
    output logic [2:0] stb
);
    localparam int CW = $clog2(OSR_DIV128);

    logic [CW-1:0] cnt_reg; // free-running count
    logic [2:0] stb_next; // strobe decode
    logic [2:0] stb_reg;

    // a strobe fires when the low bits of the count wrap
    assign stb_next[0] = &cnt_reg[$clog2(OSR_DIV8)-1:0];
    assign stb_next[1] = &cnt_reg[$clog2(OSR_DIV16)-1:0];
    assign stb_next[2] = &cnt_reg;
    assign stb = stb_reg;

    // counter and registered strobes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            stb_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            stb_reg <= stb_next;
        end
    end

    a_div8_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stb_reg[0] |=> (!stb_reg[0])[*7] ##1 stb_reg[0]) else $error("div8 strobe period wrong");
    a_div16_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stb_reg[1] |=> !stb_reg[1] ##15 stb_reg[1]) else $error("div16 strobe period wrong");
    a_div128_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stb_reg[2] |=> !stb_reg[2] ##127 stb_reg[2]) else $error("div128 strobe period wrong");
endmodule

/* File: core/osr_req_detect.sv */
// Purpose: one request detector, falling edge or sixteen low samples in a row
// Assumes: req_lvl is already synchronised and gated by the pin select
// Notes: accept is a one-cycle pulse, registered the same way in both modes
module osr_req_detect import osr_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // request level and setup
    input wire logic req_lvl,
    input wire logic [1:0] mode,
    input wire logic [2:0] stb,
    // accepted request
    output logic accept
);
    logic prev_reg; // last level, for edge detection
    logic [3:0] run_reg; // low samples seen so far
    logic [3:0] run_next;
    logic acc_reg;
    logic acc_next;
    logic samp; // sampling strobe chosen by mode
    logic edge_mode;
    logic run_full;

    assign edge_mode = (mode == OSR_MODE_EDGE);
    assign samp = (mode == OSR_MODE_DIV8) ? stb[0] : (mode == OSR_MODE_DIV16) ? stb[1] : stb[2];
    assign run_full = (run_reg == 4'(OSR_LOW_SAMPLES - 1));
    // one high sample restarts the run; a full run restarts too
    assign run_next = (edge_mode || (samp && (req_lvl || run_full))) ? 4'h0 :
                      (samp ? run_reg + 4'h1 : run_reg);
    // both paths end in the same flop, so output timing matches
    assign acc_next = edge_mode ? (prev_reg && !req_lvl) :
                      (samp && !req_lvl && run_full);
    assign accept = acc_reg;

    // detector state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b1;
            run_reg <= 4'h0;
            acc_reg <= 1'b0;
        end else begin
            prev_reg <= req_lvl;
            run_reg <= run_next;
            acc_reg <= acc_next;
        end
    end

    a_edge_accept: assert property (@(posedge clk_sys) disable iff (!rst_n)
        edge_mode && prev_reg && !req_lvl |=> acc_reg) else $error("falling edge not accepted");
    a_high_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !edge_mode && samp && req_lvl |=> run_reg == 4'h0 && !acc_reg) else $error("high sample kept run");
    a_level_accept: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !edge_mode && samp && !req_lvl && run_reg == 4'hf |=> acc_reg) else $error("full low run not accepted");
endmodule

/* File: verification/osr_fault_src.sv */
// Purpose: far-side model of the shutdown request sources driving the four pins
// Assumes: pins are pulled up, so an idle source leaves its pin high
// Notes: a pulse on go[i] pulls pin i low for len cycles, short or long
module osr_fault_src (
    // clock
    input wire logic clk_sys,
    // commands from the bench
    input wire logic [3:0] go,
    input wire logic [15:0] len,
    // request pins, active low
    output logic [3:0] shutdown_request_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // cycles left in each low pulse
    logic [15:0] low_cnt [4];

    // idle sources at time zero, so pins never start unknown
    initial begin
        for (int i = 0; i < 4; i++) begin
            low_cnt[i] = 16'h0000;
        end
    end

    // one countdown per source; changes land just after the edge
    always @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            if (go[i]) begin
                low_cnt[i] <= len;
            end else if (low_cnt[i] != 16'h0000) begin
                low_cnt[i] <= low_cnt[i] - 16'h0001;
            end
        end
    end

    // released pin goes to the pull-up level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            shutdown_request_pin_n[i] = (low_cnt[i] == 16'h0000);
        end
    end
endmodule

/* File: verification/osr_top_tb.sv */
// Purpose: self-checking bench for the output shutdown request unit
// Assumes: apb answers with zero wait states but the master never counts on it
// Notes: pin 6 is held out of motor use, so it must never be forced off
module osr_top_tb;
    import osr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and apb
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // pins, motor drive, interrupt
    logic [3:0] req_pin_n;
    logic [3:0] go = 4'h0;
    logic [15:0] len = 16'h0004;
    osr_mtr_drive_t mtr_drive = '{data: 7'h55, en: 7'h7f, is_mtr: 7'h3f};
    logic [6:0] motor_pin_out;
    logic [6:0] motor_pin_oe_n;
    logic irq;
    // bookkeeping
    int miscompares = 0;
    int n_compared = 0;
    logic [31:0] rdat;
    logic err;
    logic [31:0] w;
    int div;

    always #2 clk_sys = ~clk_sys;

    osr_fault_src src (.clk_sys(clk_sys), .go(go), .len(len), .shutdown_request_pin_n(req_pin_n));

    osr_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .shutdown_request_pin_n(req_pin_n), .mtr_drive(mtr_drive),
        .motor_pin_out(motor_pin_out), .motor_pin_oe_n(motor_pin_oe_n), .irq(irq));

    // verdict and end of run, shared with the watchdog
    task automatic wrap_up;
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one comparison, reported at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; entered and left just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // wait for the rising edge that samples pready high; only the watchdog ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        // answer taken at that same edge, then the request is released
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // two idle edges so registered outputs have settled when the caller looks
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    // pull the selected pins low for len cycles
    task automatic pulse(input logic [3:0] m, input int wait_cyc);
        go <= m;
        @(posedge clk_sys);
        go <= 4'h0;
        repeat (wait_cyc) @(posedge clk_sys);
    endtask

    // watchdog, well beyond the roughly 5000 cycles of the sequence
    initial begin
        #80000;
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // reset values and an unmapped place
        rd(OSR_ICS_OFF, 32'h0);
        rd(OSR_PINCTL_OFF, 32'h0);
        rd(OSR_EVT_MASK_OFF, 32'h0);
        rd(8'h10, 32'h0);
        chk(32'(err), 32'h1);
        // unrouted pin is seen as idle high, so it never requests
        pulse(4'h1, 12);
        rd(OSR_ICS_OFF, 32'h0);
        // route all four pins; reserved low nibble stays zero
        xfer(1'b1, OSR_PINCTL_OFF, 32'hff);
        rd(OSR_PINCTL_OFF, 32'hf0);
        // falling edge on pin 0 forces only the motor-use pins
        pulse(4'h1, 12);
        chk(32'(motor_pin_oe_n), 32'h3f);
        chk(32'(motor_pin_out), 32'h55);
        rd(OSR_ICS_OFF, 32'h1000);
        xfer(1'b1, OSR_ICS_OFF, 32'hf000);
        rd(OSR_ICS_OFF, 32'h1000);
        xfer(1'b1, OSR_ICS_OFF, 32'h0);
        rd(OSR_ICS_OFF, 32'h0);
        chk(32'(motor_pin_oe_n), 32'h0);
        // zero write without a prior read must not clear
        pulse(4'h2, 12);
        xfer(1'b1, OSR_ICS_OFF, 32'h0);
        rd(OSR_ICS_OFF, 32'h2000);
        // two flags: clearing one keeps the outputs forced
        pulse(4'h1, 12);
        rd(OSR_ICS_OFF, 32'h3000);
        xfer(1'b1, OSR_ICS_OFF, 32'h2000);
        chk(32'(motor_pin_oe_n), 32'h3f);
        rd(OSR_ICS_OFF, 32'h2000);
        xfer(1'b1, OSR_ICS_OFF, 32'h0);
        chk(32'(motor_pin_oe_n), 32'h0);
        // event status interrupt: masked, unmasked, cleared by read
        chk(32'(irq), 32'h0);
        xfer(1'b1, OSR_EVT_MASK_OFF, 32'h3);
        chk(32'(irq), 32'h1);
        rd(OSR_EVT_STAT_OFF, 32'h3);
        rd(OSR_EVT_STAT_OFF, 32'h0);
        chk(32'(irq), 32'h0);
        xfer(1'b1, OSR_EVT_MASK_OFF, 32'h0);
        // low-level modes on pin 2, interrupt enabled
        for (int m = 1; m < 4; m++) begin
            div = (m == 1) ? OSR_DIV8 : ((m == 2) ? OSR_DIV16 : OSR_DIV128);
            w = 32'h100 | (32'(m) << 4);
            xfer(1'b1, OSR_ICS_OFF, w);
            // too few low samples: refused
            len <= 16'(13 * div);
            pulse(4'h4, 13 * div + 20);
            rd(OSR_ICS_OFF, w);
            chk(32'(irq), 32'h0);
            // enough low samples: accepted
            len <= 16'(17 * div + 8);
            pulse(4'h4, 17 * div + 20);
            rd(OSR_ICS_OFF, w | 32'h4000);
            chk(32'(irq), 32'h1);
            chk(32'(motor_pin_oe_n), 32'h3f);
            xfer(1'b1, OSR_ICS_OFF, w);
            rd(OSR_ICS_OFF, w);
        end
        wrap_up();
    end
endmodule
